// file: dv/audio_clock_gen_cleaner_props.sv
// Checker for the audio clock generator and cleaner top-level ports.
// Assumes it is bound to the top level and sees its ports only.
`timescale 1ns/10ps
module audio_clock_gen_cleaner_props
   import audio_clock_pkg::*;
(
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // Pins and clocks
   input wire logic       bit_clock_pin_o,
   input wire logic       bit_clock_pin_oe,
   input wire logic       word_select_pin_o,
   input wire logic       word_select_pin_oe,
   input wire logic       audio_master_clock,
   input wire logic       audio_bit_clock,
   input wire logic       audio_word_select,
   input wire logic       clock_gen_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   localparam logic [7:0] MLIM [4] = '{MCLK_RATIO_4, MCLK_RATIO_2, MCLK_RATIO_1, MCLK_RATIO_8};
   logic [7:0] shd_q [0:6], shd_d [0:6];
   logic [7:0] bcnt_q, bcnt_d, mcnt_q, mcnt_d, blim, mlim;
   logic       bclk_q, ws_q, mclk_q, warm_q, warm_d, marm_q, marm_d, regen_ok;

   // Armed after a first edge, so start-up lag never fires them
   always_comb begin
      shd_d = shd_q;
      if (reg_write && reg_addr >= ADDR_CONTROL && reg_addr <= ADDR_N2_LOOP_FILTER_SHIFT)
         shd_d[reg_addr[2:0]] = reg_wdata;
      blim = shd_q[0][BIT_WORD_RATIO] ? BITS_PER_WORD_32 : BITS_PER_WORD_64;
      mlim = MLIM[shd_q[0][MCLK_RATIO_HI:MCLK_RATIO_LO]];
      regen_ok = shd_q[0][BIT_MASTER] && ({shd_q[3], shd_q[2], shd_q[1]} != 24'h00_0000)
                 && ({shd_q[6][NTOP_HI:NTOP_LO], shd_q[5], shd_q[4]} != 20'h0_0000);
      warm_d = shd_q[0][BIT_MASTER] && (warm_q || audio_word_select != ws_q);
      marm_d = shd_q[0][BIT_MASTER] && (marm_q || audio_bit_clock != bclk_q);
      bcnt_d = (audio_word_select != ws_q) ? 8'h00 : bcnt_q + {7'h00, audio_bit_clock != bclk_q};
      mcnt_d = (audio_bit_clock != bclk_q) ? 8'h00 : mcnt_q + {7'h00, audio_master_clock != mclk_q};
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shd_q  <= '{default: 8'h00};
         {bcnt_q, mcnt_q} <= 16'h0000;
         {bclk_q, ws_q, mclk_q, warm_q, marm_q} <= 5'h00;
      end else begin
         shd_q  <= shd_d;
         bcnt_q <= bcnt_d;
         mcnt_q <= mcnt_d;
         {bclk_q, ws_q, mclk_q} <= {audio_bit_clock, audio_word_select, audio_master_clock};
         warm_q <= warm_d;
         marm_q <= marm_d;
      end
   end

   sequence s_regen_off;
      (!regen_ok) [*3];
   endsequence
   sequence s_clean_idle;
      (shd_q[0][MODE_HI:MODE_LO] == 2'b00) [*3];
   endsequence
   sequence s_status_read;
      reg_read && reg_addr == ADDR_STATUS;
   endsequence

   property p_oe_follow;
      reg_write && reg_addr == ADDR_CONTROL |=>
         bit_clock_pin_oe == $past(reg_wdata[BIT_MASTER]) && word_select_pin_oe == bit_clock_pin_oe;
   endproperty
   property p_gen_en;
      clock_gen_enable == bit_clock_pin_oe;
   endproperty
   property p_slave_quiet;
      (!bit_clock_pin_oe) [*2] |-> !bit_clock_pin_o && !word_select_pin_o;
   endproperty
   property p_regen_off;
      s_regen_off |-> !audio_master_clock;
   endproperty
   property p_status_top;
      s_status_read |=> reg_rvalid && reg_rdata[7:6] == 2'b00;
   endproperty
   property p_clean_off;
      s_clean_idle ##0 s_status_read |=> reg_rdata == 8'h00;
   endproperty
   property p_word_len;
      warm_q |-> bcnt_q <= blim;
   endproperty
   property p_bit_len;
      marm_q |-> mcnt_q <= mlim;
   endproperty

   a_oe_follow: assert property (p_oe_follow) else $error("oe mismatch");
   a_gen_en: assert property (p_gen_en) else $error("gen enable mismatch");
   a_slave_quiet: assert property (p_slave_quiet) else $error("pin driven in slave");
   a_regen_off: assert property (p_regen_off) else $error("mclk without CTS/N");
   a_status_top: assert property (p_status_top) else $error("bad status read");
   a_clean_off: assert property (p_clean_off) else $error("fill with cleaner off");
   a_word_len: assert property (p_word_len) else $error("word too long");
   a_bit_len: assert property (p_bit_len) else $error("bit too long");
endmodule

bind audio_clock_gen_cleaner audio_clock_gen_cleaner_props u_props (.*);

// file: dv/audio_pin_peer.sv
// Model of the external serial audio device on the bit clock and word select pins.
// Assumes the bench calls send_edges; its clock stands still between bursts.
`timescale 1ns/10ps
module audio_pin_peer (
   // Clock
   input  wire logic sys_clk,
   // Design side of the pins
   input  wire logic bclk_o,
   input  wire logic bclk_oe,
   input  wire logic ws_o,
   input  wire logic ws_oe,
   // Resolved pin levels
   output logic      bclk_line,
   output logic      ws_line
);
   logic bclk_drv = 1'b0, ws_drv = 1'b0;

   // Whoever enables its driver owns the wire
   assign bclk_line = bclk_oe ? bclk_o : bclk_drv;
   assign ws_line   = ws_oe ? ws_o : ws_drv;

   task automatic send_edges(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         repeat (gap) @(negedge sys_clk);
         bclk_drv = ~bclk_drv;
         if (i % 8 == 7)
            ws_drv = ~ws_drv;
      end
   endtask
endmodule

// file: dv/test_audio_clock_gen_cleaner.sv
// Self-checking bench for the audio clock generator and cleaner.
// Assumes the checker is bound in and the pin peer resolves both pins.
`timescale 1ns/10ps
module test_audio_clock_gen_cleaner;
   import audio_clock_pkg::*;
   typedef struct {logic [7:0] d; logic [7:0] m;} note_t;
   logic       sys_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, vco_tick = 1'b0, osc_tick = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [7:0] reg_rdata, d;
   logic       reg_rvalid, bclk_line, ws_line, bclk_o, bclk_oe, ws_o, ws_oe;
   logic       audio_master_clock, audio_bit_clock, audio_word_select, clock_gen_enable;
   int         err_count = 0, check_count = 0, n;
   int         ratio_tab [4] = '{4, 2, 1, 8};
   note_t      cur;
   note_t      notes [$];

   audio_clock_gen_cleaner uut (.*, .serializer_vco_clock(vco_tick), .always_on_oscillator(osc_tick),
      .bit_clock_pin_i(bclk_line), .bit_clock_pin_o(bclk_o), .bit_clock_pin_oe(bclk_oe),
      .word_select_pin_i(ws_line), .word_select_pin_o(ws_o), .word_select_pin_oe(ws_oe));
   audio_pin_peer peer (.sys_clk(sys_clk), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .ws_o(ws_o),
      .ws_oe(ws_oe), .bclk_line(bclk_line), .ws_line(ws_line));

   initial begin
      forever #25 sys_clk = ~sys_clk;
   end

   task report_and_stop;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_int(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %0d exp %0d", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      reg_addr  = a;
      reg_wdata = v;
      reg_write = 1'b1;
      @(negedge sys_clk);
      reg_write = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge sys_clk);
      reg_addr = a;
      reg_read = 1'b1;
      notes.push_back('{e & m, m});
      @(negedge sys_clk);
      reg_read = 1'b0;
   endtask
   task tick(input bit vco);
      @(negedge sys_clk);
      vco_tick = vco;
      osc_tick = !vco;
      @(negedge sys_clk);
      {vco_tick, osc_tick} = 2'b00;
   endtask
   task wait_edge(input bit ws, output int cyc);
      logic v0;
      v0 = ws ? audio_word_select : audio_bit_clock;
      for (cyc = 1; cyc <= 400; cyc++) begin
         @(negedge sys_clk);
         if ((ws ? audio_word_select : audio_bit_clock) !== v0)
            return;
      end
      err_count++;
      $display("CHECK FAILED at %0t: no clock edge", $time);
      report_and_stop();
   endtask
   task count_mclk(input int len, output int t);
      logic p;
      t = 0;
      repeat (len) begin
         p = audio_master_clock;
         @(negedge sys_clk);
         if (audio_master_clock !== p)
            t++;
      end
   endtask
   task restart(input logic [7:0] ctl);
      wr(ADDR_CONTROL, 8'h00);
      repeat (4) @(negedge sys_clk);
      wr(ADDR_CONTROL, ctl);
   endtask

   always @(negedge sys_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (notes.size() == 0) begin
            err_count++;
            $display("CHECK FAILED at %0t: unrequested read data", $time);
         end else begin
            cur = notes.pop_front();
            cmp8(reg_rdata & cur.m, cur.d);
         end
      end
   end

   initial begin
      void'($urandom(10518));
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      for (int a = 'h30; a <= 'h37; a++) rd(8'(a), RESET_BYTE, 8'hff);
      for (int a = 'h31; a <= 'h36; a++) begin
         d = 8'($urandom);
         wr(8'(a), d);
         rd(8'(a), d, 8'hff);
      end
      wr(ADDR_STATUS, 8'hff);
      wr(8'h2f, 8'hff);
      rd(ADDR_STATUS, 8'h00, 8'hff);
      rd(8'h2f, READ_UNMAPPED, 8'hff);
      for (int a = 'h31; a <= 'h36; a++) wr(8'(a), (a == 'h34) ? 8'h01 : 8'h00);
      wr(ADDR_CONTROL, 8'h41);
      rd(ADDR_CONTROL, 8'h41, 8'hff);
      cmp8({6'h00, bclk_oe, ws_oe}, 8'h03);
      cmp8({7'h00, clock_gen_enable}, 8'h01);
      count_mclk(20, n);
      cmp_int(n, 0);
      wr(ADDR_CTS0, 8'h01);
      repeat (4) @(negedge sys_clk);
      count_mclk(20, n);
      cmp_int(n, 20);
      for (int c = 0; c < 4; c++) begin
         restart({1'b0, 2'(c), 5'h01});
         repeat (3) wait_edge(1'b0, n);
         cmp_int(n, ratio_tab[c]);
      end
      for (int b = 0; b < 2; b++) begin
         restart({1'(b), 2'b10, 5'h01});
         repeat (3) wait_edge(1'b1, n);
         cmp_int(n, (b == 1) ? 32 : 64);
      end
      restart(8'h02);
      cmp8({6'h00, bclk_oe, ws_oe}, 8'h00);
      peer.send_edges(10, 4);
      repeat (4) @(negedge sys_clk);
      rd(ADDR_STATUS, 8'h38, 8'hff);
      wr(ADDR_CONTROL, 8'h1a);
      repeat (3) tick(1'b0);
      rd(ADDR_STATUS, 8'h20, 8'h38);
      wr(ADDR_CONTROL, 8'h12);
      repeat (2) tick(1'b1);
      rd(ADDR_STATUS, 8'h18, 8'h38);
      wr(ADDR_CONTROL, 8'h00);
      repeat (3) @(negedge sys_clk);
      rd(ADDR_STATUS, 8'h00, 8'hff);
      repeat (3) @(negedge sys_clk);
      cmp_int(notes.size(), 0);
      report_and_stop();
   end
endmodule

// file: hw/audio_clock_gen_cleaner.sv
// Audio clock generator and cleaner: register file, N/CTS regeneration,
// bit clock and word select generation, and pin direction control.
// Assumes a same-clock register port and VCO/oscillator ticks from sys_clk logic.
//
// How it works
// RL1: Control bit picks 64 or 32 bits/word
// RL2: Two-bit field picks master/bit ratio 4,2,1,8
// RL3: Nonzero mode cleans edges against divided reference
// RL4: Master bit drives both pins, enables generation
// RL5: Nonzero CTS and N regenerate master clock when the master bit is set
// RL6: Feedback step divided by two to coefficient
// RL7: Status shows input and output fill levels
`timescale 1ns/10ps
module audio_clock_gen_cleaner (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // Reference ticks
   input  wire logic       serializer_vco_clock,
   input  wire logic       always_on_oscillator,
   // Bit clock pin
   input  wire logic       bit_clock_pin_i,
   output logic            bit_clock_pin_o,
   output logic            bit_clock_pin_oe,
   // Word select pin
   input  wire logic       word_select_pin_i,
   output logic            word_select_pin_o,
   output logic            word_select_pin_oe,
   // Internal audio clocks
   output logic            audio_master_clock,
   output logic            audio_bit_clock,
   output logic            audio_word_select,
   output logic            clock_gen_enable
);
   import audio_clock_pkg::*;

   cleaner_if cif ();

   // Register file
   logic [7:0]  control_q,  control_d;
   logic [7:0]  cts0_q,     cts0_d;
   logic [7:0]  cts1_q,     cts1_d;
   logic [7:0]  cts2_q,     cts2_d;
   logic [7:0]  n0_q,       n0_d;
   logic [7:0]  n1_q,       n1_d;
   logic [7:0]  n2_loop_filter_shift_q, n2_loop_filter_shift_d;
   logic [7:0]  rdata_q,    rdata_d;
   logic        rvalid_q,   rvalid_d;
   logic [7:0]  status;

   // Decoded fields
   logic        master;
   logic [7:0]  bits_per_word_ratio;
   logic [7:0]  mclk_ratio;
   logic [3:0]  loop_filter_shift;
   logic [23:0] cts;
   logic [19:0] n_div;
   logic        regen_on;

   // Regeneration and generation state
   logic [24:0] acc_q,   acc_d;
   logic        mtick_q, mtick_d;
   logic        mclk_q,  mclk_d;
   logic        bclk_q,  bclk_d;
   logic        ws_q,    ws_d;
   logic        gen_edge;
   logic        ws_tick;
   logic        bit_edge;

   // Pin synchronisers
   logic [1:0]  bclk_sync_q;
   logic [1:0]  ws_sync_q;
   logic        bclk_in_prev_q;
   logic        slave_edge;

   function automatic logic [7:0] mclk_ratio_of(input logic [1:0] code);
      logic [7:0] r;
      r = MCLK_RATIO_4;
      unique case (code)
         2'b00: r = MCLK_RATIO_4;
         2'b01: r = MCLK_RATIO_2;
         2'b10: r = MCLK_RATIO_1;
         2'b11: r = MCLK_RATIO_8;
      endcase
      return r;
   endfunction

   always_comb begin
      master              = control_q[BIT_MASTER];
      bits_per_word_ratio = control_q[BIT_WORD_RATIO] ? BITS_PER_WORD_32 : BITS_PER_WORD_64; // RL1
      mclk_ratio          = mclk_ratio_of(control_q[MCLK_RATIO_HI:MCLK_RATIO_LO]); // RL2
      loop_filter_shift   = n2_loop_filter_shift_q[SHIFT_HI:SHIFT_LO];
      cts                 = {cts2_q, cts1_q, cts0_q}; // RL5
      n_div               = {n2_loop_filter_shift_q[NTOP_HI:NTOP_LO], n1_q, n0_q}; // RL5
      regen_on            = master && (cts != 24'h00_0000) && (n_div != 20'h0_0000); // RL5
      status              = 8'h00;
      status[IN_FILL_HI:IN_FILL_LO]   = cif.in_fill; // RL7
      status[OUT_FILL_HI:OUT_FILL_LO] = cif.out_fill; // RL7
   end

   // Register writes and reads; status is read-only, unmapped reads give zero
   always_comb begin
      control_d  = control_q;
      cts0_d     = cts0_q;
      cts1_d     = cts1_q;
      cts2_d     = cts2_q;
      n0_d       = n0_q;
      n1_d       = n1_q;
      n2_loop_filter_shift_d = n2_loop_filter_shift_q;
      rvalid_d   = reg_read;
      rdata_d    = rdata_q;
      if (reg_write) begin
         unique case (reg_addr)
            ADDR_CONTROL:  control_d  = reg_wdata;
            ADDR_CTS0:     cts0_d     = reg_wdata;
            ADDR_CTS1:     cts1_d     = reg_wdata;
            ADDR_CTS2:     cts2_d     = reg_wdata;
            ADDR_N0:       n0_d       = reg_wdata;
            ADDR_N1:       n1_d       = reg_wdata;
            ADDR_N2_LOOP_FILTER_SHIFT: n2_loop_filter_shift_d = reg_wdata;
            default:       control_d  = control_q;
         endcase
      end
      if (reg_read) begin
         unique case (reg_addr)
            ADDR_CONTROL:  rdata_d = control_q;
            ADDR_CTS0:     rdata_d = cts0_q;
            ADDR_CTS1:     rdata_d = cts1_q;
            ADDR_CTS2:     rdata_d = cts2_q;
            ADDR_N0:       rdata_d = n0_q;
            ADDR_N1:       rdata_d = n1_q;
            ADDR_N2_LOOP_FILTER_SHIFT: rdata_d = n2_loop_filter_shift_q;
            ADDR_STATUS:   rdata_d = status; // RL7
            default:       rdata_d = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         control_q  <= RESET_BYTE;
         cts0_q     <= RESET_BYTE;
         cts1_q     <= RESET_BYTE;
         cts2_q     <= RESET_BYTE;
         n0_q       <= RESET_BYTE;
         n1_q       <= RESET_BYTE;
         n2_loop_filter_shift_q <= RESET_BYTE;
         rdata_q    <= RESET_BYTE;
         rvalid_q   <= 1'b0;
      end else begin
         control_q  <= control_d;
         cts0_q     <= cts0_d;
         cts1_q     <= cts1_d;
         cts2_q     <= cts2_d;
         n0_q       <= n0_d;
         n1_q       <= n1_d;
         n2_loop_filter_shift_q <= n2_loop_filter_shift_d;
         rdata_q    <= rdata_d;
         rvalid_q   <= rvalid_d;
      end
   end

   // Fractional N/CTS accumulator; one master clock edge per CTS worth of N.
   // Only one edge per sys_clk cycle, so N above CTS saturates the rate.
   always_comb begin
      acc_d   = acc_q;
      mtick_d = 1'b0;
      mclk_d  = mclk_q;
      if (!regen_on) begin
         acc_d  = 25'h000_0000;
         mclk_d = 1'b0;
      end else if (acc_q + {5'h00, n_div} >= {1'b0, cts}) begin
         acc_d   = 25'(acc_q + {5'h00, n_div} - {1'b0, cts}); // RL5
         mtick_d = 1'b1;
         mclk_d  = !mclk_q;
      end else begin
         acc_d = 25'(acc_q + {5'h00, n_div}); // RL5
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q   <= 25'h000_0000;
         mtick_q <= 1'b0;
         mclk_q  <= 1'b0;
      end else begin
         acc_q   <= acc_d;
         mtick_q <= mtick_d;
         mclk_q  <= mclk_d;
      end
   end

   // Master clock edges divided down to bit clock edges
   edge_divider #(.W(8)) u_bit_div (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clear    (!regen_on),
      .ratio    (mclk_ratio), // RL2
      .tick_in  (mtick_q),
      .tick_out (gen_edge)
   );

   // Pins from outside pass two flip-flops before use
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_sync_q    <= 2'b00;
         ws_sync_q      <= 2'b00;
         bclk_in_prev_q <= 1'b0;
      end else begin
         bclk_sync_q    <= {bclk_sync_q[0], bit_clock_pin_i};
         ws_sync_q      <= {ws_sync_q[0], word_select_pin_i};
         bclk_in_prev_q <= bclk_sync_q[1];
      end
   end

   assign slave_edge = bclk_sync_q[1] != bclk_in_prev_q;

   // Cleaner hookup; edges bypass it when the mode is off
   assign cif.enable   = control_q[MODE_HI:MODE_LO] != 2'b00; // RL3
   assign cif.mode     = clean_mode_t'(control_q[MODE_HI:MODE_LO]);
   assign cif.ref_sel  = ref_sel_t'(control_q[REF_SEL_HI:REF_SEL_LO]);
   assign cif.shift    = loop_filter_shift; // RL6
   assign cif.vco_tick = serializer_vco_clock;
   assign cif.osc_tick = always_on_oscillator;
   assign cif.raw_edge = master ? gen_edge : slave_edge; // RL3
   assign bit_edge     = cif.enable ? cif.clean_edge : cif.raw_edge; // RL3

   clock_cleaner u_cleaner (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .cif     (cif)
   );

   // Word select toggles after one word's worth of bit clock edges
   edge_divider #(.W(8)) u_ws_div (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clear    (!master),
      .ratio    (bits_per_word_ratio), // RL1
      .tick_in  (master && bit_edge),
      .tick_out (ws_tick)
   );

   always_comb begin
      bclk_d = bclk_q;
      ws_d   = ws_q;
      if (master) begin
         if (bit_edge) begin
            bclk_d = !bclk_q; // RL4
         end
         if (ws_tick) begin
            ws_d = !ws_q; // RL4
         end
      end else begin
         // Slave: internal clocks follow the synchronised pins
         if (bit_edge) begin
            bclk_d = bclk_sync_q[1];
         end
         ws_d = ws_sync_q[1];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_q <= 1'b0;
         ws_q   <= 1'b0;
      end else begin
         bclk_q <= bclk_d;
         ws_q   <= ws_d;
      end
   end

   assign reg_rdata          = rdata_q;
   assign reg_rvalid         = rvalid_q;
   assign bit_clock_pin_o    = master ? bclk_q : 1'b0;
   assign word_select_pin_o  = master ? ws_q : 1'b0;
   assign bit_clock_pin_oe   = master; // RL4
   assign word_select_pin_oe = master; // RL4
   assign clock_gen_enable   = master; // RL4
   assign audio_master_clock = mclk_q;
   assign audio_bit_clock    = bclk_q;
   assign audio_word_select  = ws_q;
endmodule

// file: hw/audio_clock_pkg.sv
// Constants shared by the audio clock generator and clock cleaner.
// Assumes an 8-bit register port and a single 20 MHz system clock.
package audio_clock_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_CONTROL  = 8'h30;
   localparam logic [7:0] ADDR_CTS0     = 8'h31;
   localparam logic [7:0] ADDR_CTS1     = 8'h32;
   localparam logic [7:0] ADDR_CTS2     = 8'h33;
   localparam logic [7:0] ADDR_N0       = 8'h34;
   localparam logic [7:0] ADDR_N1       = 8'h35;
   localparam logic [7:0] ADDR_N2_LOOP_FILTER_SHIFT = 8'h36;
   localparam logic [7:0] ADDR_STATUS   = 8'h37;

   // Reset values
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Control register field positions
   localparam int BIT_WORD_RATIO = 7;
   localparam int MCLK_RATIO_HI  = 6;
   localparam int MCLK_RATIO_LO  = 5;
   localparam int REF_SEL_HI     = 4;
   localparam int REF_SEL_LO     = 3;
   localparam int MODE_HI        = 2;
   localparam int MODE_LO        = 1;
   localparam int BIT_MASTER     = 0;

   // Divisor top / filter register fields
   localparam int SHIFT_HI = 7;
   localparam int SHIFT_LO = 4;
   localparam int NTOP_HI  = 3;
   localparam int NTOP_LO  = 0;

   // Status register fields
   localparam int IN_FILL_HI  = 5;
   localparam int IN_FILL_LO  = 3;
   localparam int OUT_FILL_HI = 2;
   localparam int OUT_FILL_LO = 0;

   // Ratios, held as counts of clock edges
   localparam logic [7:0] BITS_PER_WORD_64 = 8'h40;
   localparam logic [7:0] BITS_PER_WORD_32 = 8'h20;
   localparam logic [7:0] MCLK_RATIO_4     = 8'h04;
   localparam logic [7:0] MCLK_RATIO_2     = 8'h02;
   localparam logic [7:0] MCLK_RATIO_1     = 8'h01;
   localparam logic [7:0] MCLK_RATIO_8     = 8'h08;

   // Cleaner constants
   localparam logic [2:0] FILL_MAX      = 3'h7;
   localparam logic [2:0] FILL_HALF     = 3'h4;
   localparam logic [7:0] PERIOD_RESET  = 8'h10;
   localparam logic [7:0] PERIOD_STEP   = 8'h10;
   localparam logic [7:0] PERIOD_MIN    = 8'h01;
   localparam logic [7:0] PERIOD_MAX    = 8'hff;

   typedef enum logic [1:0] {
      CLEAN_OFF,
      CLEAN_RATIO_1,
      CLEAN_RATIO_2,
      CLEAN_RATIO_4
   } clean_mode_t;

   typedef enum logic [1:0] {
      REF_VCO_DIV8,
      REF_VCO_DIV4,
      REF_VCO_DIV2,
      REF_OSC
   } ref_sel_t;
endpackage

// file: hw/cleaner_if.sv
// Bundle between the top level and the digital clock cleaner.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface cleaner_if;
   logic                      enable;
   audio_clock_pkg::ref_sel_t ref_sel;
   logic [3:0]                shift;
   logic                      vco_tick;
   logic                      osc_tick;
   logic                      raw_edge;
   logic                      clean_edge;
   logic [2:0]                in_fill;
   logic [2:0]                out_fill;
   audio_clock_pkg::clean_mode_t mode;

   modport ctrl (output enable, ref_sel, mode, shift, vco_tick, osc_tick, raw_edge,
                 input clean_edge, in_fill, out_fill);
   modport core (input enable, ref_sel, mode, shift, vco_tick, osc_tick, raw_edge,
                 output clean_edge, in_fill, out_fill);
endinterface

// file: hw/clock_cleaner.sv
// Digital clock cleaner: buffers raw clock edges and replays them evenly.
// Assumes one sys_clk domain; reference ticks are one-cycle enables.
`timescale 1ns/10ps
module clock_cleaner (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Cleaner bundle
   cleaner_if.core   cif
);
   import audio_clock_pkg::*;

   logic [7:0] ref_ratio;
   logic       ref_src;
   logic       ref_strobe;
   logic [2:0] in_fill_q,  in_fill_d;
   logic [2:0] out_fill_q, out_fill_d;
   logic [7:0] period_q,   period_d;
   logic [7:0] timer_q,    timer_d;
   logic       edge_q,     edge_d;
   logic       move;
   logic [7:0] step;

   // Reference: VCO divided by 8, 4 or 2, or the oscillator, then by the mode ratio
   always_comb begin
      ref_src   = cif.vco_tick;
      ref_ratio = 8'h01;
      unique case (cif.ref_sel)
         REF_VCO_DIV8: ref_ratio = 8'h08;
         REF_VCO_DIV4: ref_ratio = 8'h04;
         REF_VCO_DIV2: ref_ratio = 8'h02;
         REF_OSC: begin
            ref_src   = cif.osc_tick;
            ref_ratio = 8'h01;
         end
      endcase
      unique case (cif.mode)
         CLEAN_OFF:     ref_ratio = ref_ratio;
         CLEAN_RATIO_1: ref_ratio = ref_ratio;
         CLEAN_RATIO_2: ref_ratio = 8'(ref_ratio << 1);
         CLEAN_RATIO_4: ref_ratio = 8'(ref_ratio << 2);
      endcase
   end // RL3

   edge_divider #(.W(8)) u_ref_div (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clear    (!cif.enable),
      .ratio    (ref_ratio),
      .tick_in  (ref_src),
      .tick_out (ref_strobe)
   );

   // Feedback step shrinks by a power of two per filter coefficient
   assign step = PERIOD_STEP >> cif.shift; // RL6
   assign move = ref_strobe && (in_fill_q != 3'h0) && (out_fill_q != FILL_MAX);

   always_comb begin
      in_fill_d  = in_fill_q;
      out_fill_d = out_fill_q;
      period_d   = period_q;
      timer_d    = timer_q;
      edge_d     = 1'b0;
      if (!cif.enable) begin
         in_fill_d  = 3'h0;
         out_fill_d = 3'h0;
         period_d   = PERIOD_RESET;
         timer_d    = 8'h00;
      end else begin
         // A raw edge and a transfer in one cycle cancel, so no edge is lost
         if (cif.raw_edge && !move && in_fill_q != FILL_MAX) begin
            in_fill_d = in_fill_q + 3'h1;
         end else if (move && !cif.raw_edge) begin
            in_fill_d = in_fill_q - 3'h1;
         end
         if (timer_q != PERIOD_MAX) begin
            timer_d = timer_q + 8'h01;
         end
         if (timer_q >= period_q && out_fill_q != 3'h0) begin
            edge_d     = 1'b1;
            timer_d    = 8'h00;
            out_fill_d = move ? out_fill_q : out_fill_q - 3'h1;
            if (out_fill_q > FILL_HALF) begin
               period_d = (period_q > PERIOD_MIN + step) ? period_q - step : PERIOD_MIN; // RL6
            end else if (out_fill_q < FILL_HALF) begin
               period_d = (period_q < PERIOD_MAX - step) ? period_q + step : PERIOD_MAX; // RL6
            end
         end else if (move) begin
            out_fill_d = out_fill_q + 3'h1;
         end
      end
   end // RL3

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_fill_q  <= 3'h0;
         out_fill_q <= 3'h0;
         period_q   <= PERIOD_RESET;
         timer_q    <= 8'h00;
         edge_q     <= 1'b0;
      end else begin
         in_fill_q  <= in_fill_d;
         out_fill_q <= out_fill_d;
         period_q   <= period_d;
         timer_q    <= timer_d;
         edge_q     <= edge_d;
      end
   end

   assign cif.clean_edge = edge_q;
   assign cif.in_fill    = in_fill_q; // RL7
   assign cif.out_fill   = out_fill_q; // RL7
endmodule

// file: hw/edge_divider.sv
// Divides a stream of one-cycle ticks by a programmable ratio.
// Assumes ticks and ratio are on sys_clk; a ratio of zero acts as one.
`timescale 1ns/10ps
module edge_divider #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         clear,
   input  wire logic [W-1:0] ratio,
   // Ticks
   input  wire logic         tick_in,
   output logic              tick_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         out_q;
   logic         out_d;

   always_comb begin
      cnt_d = cnt_q;
      out_d = 1'b0;
      if (clear) begin
         cnt_d = '0;
      end else if (tick_in) begin
         if (cnt_q + W'(1) >= ratio) begin
            cnt_d = '0;
            out_d = 1'b1;
         end else begin
            cnt_d = cnt_q + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign tick_out = out_q;
endmodule
